/* common/pfdma_pkg.sv */
/*
 * Shared constants and types of the playfield fetch block: register
 * offsets, reset values, cycle positions and the per-mode rate record.
 * Assumes one 20 MHz clock at colour clock rate; a machine cycle is two
 * clock edges.
 */
`default_nettype none
package pfdma_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses on APB)
    // ------------------------------------------------------------
    localparam logic [11:0] PFDMA_DMA_CONTROL_OFF = 12'h000;
    localparam logic [11:0] PFDMA_HSCROLL_OFF     = 12'h004;
    localparam logic [11:0] PFDMA_STATUS_OFF      = 12'h008;
    localparam logic [1:0]  PFDMA_DMA_CONTROL_RST = 2'h0;
    localparam logic [3:0]  PFDMA_HSCROLL_RST     = 4'h0;

    // ------------------------------------------------------------
    // Scan line timing in machine cycles
    // ------------------------------------------------------------
    localparam int          PFDMA_LINE_CYCLES   = 114;
    localparam logic [6:0]  PFDMA_LAST_CYCLE    = 7'h71;
    localparam logic [6:0]  PFDMA_SPECIAL_END   = 7'h08; // 0-7 special
    localparam logic [6:0]  PFDMA_START_NARROW  = 7'h18; // 24
    localparam logic [6:0]  PFDMA_START_NORMAL  = 7'h10; // 16
    localparam logic [6:0]  PFDMA_START_WIDE    = 7'h08; // 8
    localparam logic [6:0]  PFDMA_STOP_NARROW   = 7'h58; // 88
    localparam logic [6:0]  PFDMA_STOP_NORMAL   = 7'h60; // 96
    localparam logic [6:0]  PFDMA_STOP_WIDE     = 7'h68; // 104
    localparam int          PFDMA_BUF_DEPTH     = 48;

    // Width field codes
    localparam logic [1:0]  PFDMA_W_OFF    = 2'h0;
    localparam logic [1:0]  PFDMA_W_NARROW = 2'h1;
    localparam logic [1:0]  PFDMA_W_NORMAL = 2'h2;
    localparam logic [1:0]  PFDMA_W_WIDE   = 2'h3;

    // Fetch and shift rate codes
    typedef enum logic [1:0] {
        PFDMA_FAST,
        PFDMA_MEDIUM,
        PFDMA_SLOW
    } pfdma_rate_t;

    typedef struct packed {
        pfdma_rate_t dma_rate;
        pfdma_rate_t shift_rate;
        logic        two_bit;
    } pfdma_mode_info_t;

    // Shift clock patterns injected on a data fetch
    localparam logic [3:0] PFDMA_SCLK_FAST   = 4'hf;
    localparam logic [3:0] PFDMA_SCLK_MEDIUM = 4'h5;
    localparam logic [3:0] PFDMA_SCLK_SLOW   = 4'h1;
endpackage : pfdma_pkg
`default_nettype wire

/* rtl/pfdma_line_buffer.sv */
/*
 * Playfield fetch scheduler with line buffer, DMA clock ring and
 * graphics shift clock, with an APB register slave.
 * Assumes clk_in is the colour clock; first_line_in, vblank_in, mode_in
 * and bus_data_in come from logic on the same clock and pass no
 * synchroniser.
 */
// Register access over APB and the placing of the registers were chosen for this implementation.
//
// Contract
// - Buffer written only on first-line name/bitmap slots
// - Load counts follow width and fetch rate
// - DMA off after start: capture bus, count
// - Playfield never started: buffer untouched
// - Buffer never cleared
// - Buffer index zero at playfield start
// - Replay reinterpreted by the current mode
// - Start/stop from width and scroll bits 3:1
// - Start deadlines 24/16/8 plus scroll half
// - Late later-start ignored this line
// - Late earlier-start means no playfield
// - Stop deadlines 88/96/104, later extends
// - Wide stop always armed as fallback
// - Width 00 disables DMA, shows background
// - Off before start: no count, no load
// - Invert state frozen while DMA off
// - Skipped entries keep stale data
// - DMA ring 2/4/8 with taps 0,+2,+3
// - Inject at start, clear at stop/blank
// - Four-bit shift clock with rate patterns
// - Shift clock cleared cycles 0-7
// - Mode table selects rates and shift
// - 48-byte internal line buffer
`timescale 1ns/1ps
`default_nettype none
module pfdma_line_buffer
    import pfdma_pkg::*;
#(
    parameter int BUF_DEPTH = PFDMA_BUF_DEPTH
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic [3:0]  mode_in,
    input  wire logic        first_line_in,
    input  wire logic        vblank_in,
    input  wire logic [7:0]  bus_data_in,
    output logic             dma_req_out,
    output logic      [1:0]  dma_kind_out,
    output logic             mem_scan_inc_out,
    output logic      [1:0]  pixel_out,
    output logic             background_out,
    output logic             invert_out,
    output logic      [6:0]  cycle_out
);
    if (BUF_DEPTH != PFDMA_BUF_DEPTH) begin : g_depth_check
        // Index width and load counts assume exactly 48 entries
        $error("BUF_DEPTH must be 48");
    end

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    // Start position for a width, before scroll
    function automatic logic [6:0] start_base(input logic [1:0] w);
        case (w)
            PFDMA_W_NARROW: start_base = PFDMA_START_NARROW;
            PFDMA_W_NORMAL: start_base = PFDMA_START_NORMAL;
            default:        start_base = PFDMA_START_WIDE;
        endcase
    endfunction : start_base

    function automatic logic [6:0] stop_base(input logic [1:0] w);
        case (w)
            PFDMA_W_NARROW: stop_base = PFDMA_STOP_NARROW;
            PFDMA_W_NORMAL: stop_base = PFDMA_STOP_NORMAL;
            default:        stop_base = PFDMA_STOP_WIDE;
        endcase
    endfunction : stop_base

    // Rate table by mode
    function automatic pfdma_mode_info_t mode_info(input logic [3:0] m);
        case (m)
            4'h2, 4'h3, 4'h4, 4'h5,
            4'hd, 4'he, 4'hf:
                mode_info = '{PFDMA_FAST, PFDMA_FAST, 1'b1};
            4'h6, 4'h7, 4'hb, 4'hc:
                mode_info = '{PFDMA_MEDIUM, PFDMA_FAST, 1'b0};
            4'h8:    mode_info = '{PFDMA_SLOW, PFDMA_SLOW, 1'b1};
            4'h9:    mode_info = '{PFDMA_SLOW, PFDMA_MEDIUM, 1'b0};
            4'ha:    mode_info = '{PFDMA_MEDIUM, PFDMA_MEDIUM, 1'b1};
            default: mode_info = '{PFDMA_FAST, PFDMA_FAST, 1'b1};
        endcase
    endfunction : mode_info

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    logic [1:0] dma_control_reg;
    logic [3:0] horizontal_scroll_reg;
    logic       apb_wr;
    logic       mapped;
    logic [5:0] buf_idx_reg;
    logic       pf_active_reg;
    logic [6:0] hcount_reg;

    assign mapped = (paddr_in == PFDMA_DMA_CONTROL_OFF)
                  || (paddr_in == PFDMA_HSCROLL_OFF)
                  || (paddr_in == PFDMA_STATUS_OFF);
    assign apb_wr = psel_in && penable_in && pwrite_in && mapped;
    assign pready_out = 1'b1; // Zero wait states
    assign pslverr_out = psel_in && penable_in && !mapped;

    // Control registers written by software steer the fetch timing
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            dma_control_reg       <= PFDMA_DMA_CONTROL_RST;
            horizontal_scroll_reg <= PFDMA_HSCROLL_RST;
        end else if (apb_wr) begin
            if (paddr_in == PFDMA_DMA_CONTROL_OFF)
                dma_control_reg <= pwdata_in[1:0];
            if (paddr_in == PFDMA_HSCROLL_OFF)
                horizontal_scroll_reg <= pwdata_in[3:0];
        end
    end

    // Read mux; status shows live position and buffer index
    always_comb begin
        prdata_out = 32'h0;
        case (paddr_in)
            PFDMA_DMA_CONTROL_OFF: prdata_out[1:0] = dma_control_reg;
            PFDMA_HSCROLL_OFF:     prdata_out[3:0] = horizontal_scroll_reg;
            PFDMA_STATUS_OFF:
                prdata_out[14:0] = {pf_active_reg, buf_idx_reg, 1'b0,
                                    hcount_reg};
            default:               prdata_out = 32'h0;
        endcase
    end

    // ------------------------------------------------------------
    // Machine cycle phase and horizontal position
    // ------------------------------------------------------------
    logic phase_reg;
    logic mach;
    assign mach = phase_reg;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in)
            phase_reg <= 1'b0;
        else
            phase_reg <= !phase_reg;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in)
            hcount_reg <= 7'h0;
        else if (mach)
            hcount_reg <= (hcount_reg == PFDMA_LAST_CYCLE) ? 7'h0
                        : hcount_reg + 7'h1;
    end
    assign cycle_out = hcount_reg;

    // ------------------------------------------------------------
    // Start and stop decision
    // ------------------------------------------------------------
    // Positions are evaluated live every cycle, so a write only counts
    // if it lands before the comparison point; no latching per line.
    logic       pf_enabled;
    logic [6:0] scroll_add;
    logic       start_evt;
    logic       stop_evt;
    logic       is_char;
    logic       blank_mode;
    pfdma_mode_info_t info;

    assign pf_enabled = (dma_control_reg != PFDMA_W_OFF);
    assign scroll_add = {4'h0, horizontal_scroll_reg[3:1]};
    assign start_evt = mach && pf_enabled && !pf_active_reg && !blank_mode
                     && (hcount_reg == start_base(dma_control_reg)
                                       + scroll_add);
    // Wide stop is always compared as a second chance
    assign stop_evt = mach && pf_active_reg
                    && ((hcount_reg == stop_base(dma_control_reg)
                                       + scroll_add)
                     || (hcount_reg == PFDMA_STOP_WIDE
                                       + scroll_add));
    assign is_char = (mode_in >= 4'h2) && (mode_in <= 4'h7);
    assign blank_mode = (mode_in <= 4'h1) || vblank_in;
    assign info = mode_info(mode_in);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in)
            pf_active_reg <= 1'b0;
        else if (blank_mode || stop_evt)
            pf_active_reg <= 1'b0;
        else if (start_evt)
            pf_active_reg <= 1'b1;
    end

    // ------------------------------------------------------------
    // DMA clock ring
    // ------------------------------------------------------------
    // Eight bits always shift; only the feedback tap follows the rate,
    // so taps +2 and +3 exist even for a two-long ring.
    logic [7:0] dma_ring_reg;
    logic       ring_fb;

    always_comb begin
        case (info.dma_rate)
            PFDMA_FAST:   ring_fb = dma_ring_reg[1];
            PFDMA_MEDIUM: ring_fb = dma_ring_reg[3];
            default:      ring_fb = dma_ring_reg[7];
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in)
            dma_ring_reg <= 8'h0;
        else if (blank_mode)
            dma_ring_reg <= 8'h0;
        else if (mach)
            dma_ring_reg <= {dma_ring_reg[6:0],
                             (ring_fb && !stop_evt) || start_evt};
    end

    // ------------------------------------------------------------
    // Fetch slots and bus requests
    // ------------------------------------------------------------
    logic name_slot;
    logic bitmap_slot;
    logic chdata_slot;
    logic load_slot;
    logic data_slot;

    assign name_slot   = mach && dma_ring_reg[0] && is_char;
    assign bitmap_slot = mach && dma_ring_reg[2] && !is_char;
    assign chdata_slot = mach && dma_ring_reg[3] && is_char;
    assign load_slot   = name_slot || bitmap_slot;
    assign data_slot   = bitmap_slot || chdata_slot;

    // Bus cycles only while enabled; slots keep running when off
    always_comb begin
        dma_req_out  = 1'b0;
        dma_kind_out = 2'h0;
        if (pf_enabled) begin
            if (first_line_in && name_slot) begin
                dma_req_out  = 1'b1;
                dma_kind_out = 2'h1;
            end else if (first_line_in && bitmap_slot) begin
                dma_req_out  = 1'b1;
                dma_kind_out = 2'h2;
            end else if (chdata_slot) begin
                dma_req_out  = 1'b1;
                dma_kind_out = 2'h3;
            end
        end
    end

    // Scan counter advances on every first-line name/bitmap slot, enabled or not
    assign mem_scan_inc_out = first_line_in && load_slot;

    // ------------------------------------------------------------
    // Line buffer
    // ------------------------------------------------------------
    logic [7:0] line_buf_reg [BUF_DEPTH];
    logic       buf_we;
    logic [7:0] slot_byte;

    // Index restarts at playfield start, so replay follows the border
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in)
            buf_idx_reg <= 6'h0;
        else if (start_evt)
            buf_idx_reg <= 6'h0;
        else if (load_slot && buf_idx_reg != 6'(BUF_DEPTH - 1))
            buf_idx_reg <= buf_idx_reg + 6'h1;
    end

    // Only ring-driven slots write; no start means no write at all
    assign buf_we = first_line_in && load_slot;

    // No reset: contents persist and are never cleared
    always_ff @(posedge clk_in) begin
        if (buf_we)
            line_buf_reg[buf_idx_reg] <= bus_data_in;
    end

    assign slot_byte = first_line_in ? bus_data_in
                                     : line_buf_reg[buf_idx_reg];

    // ------------------------------------------------------------
    // Character invert state
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in)
            invert_out <= 1'b0;
        else if (name_slot && pf_enabled
                 && (mode_in == 4'h2 || mode_in == 4'h3))
            invert_out <= slot_byte[7];
    end

    // ------------------------------------------------------------
    // Shift clock and graphics shift register
    // ------------------------------------------------------------
    logic [3:0] sclk_reg;
    logic [7:0] gfx_reg;
    logic [3:0] sclk_seed;
    logic       special;

    assign special = (hcount_reg < PFDMA_SPECIAL_END);

    always_comb begin
        case (info.shift_rate)
            PFDMA_FAST:   sclk_seed = PFDMA_SCLK_FAST;
            PFDMA_MEDIUM: sclk_seed = PFDMA_SCLK_MEDIUM;
            default:      sclk_seed = PFDMA_SCLK_SLOW;
        endcase
    end

    // Ring keeps turning past stop to drain the shift register
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in)
            sclk_reg <= 4'h0;
        else if (special)
            sclk_reg <= 4'h0;
        else if (data_slot)
            sclk_reg <= sclk_seed;
        else
            sclk_reg <= {sclk_reg[2:0], sclk_reg[3]};
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in)
            gfx_reg <= 8'h0;
        else if (special)
            gfx_reg <= 8'h0;
        else if (data_slot)
            gfx_reg <= chdata_slot ? bus_data_in : slot_byte;
        else if (sclk_reg[3])
            gfx_reg <= info.two_bit ? {gfx_reg[5:0], 2'h0}
                                    : {gfx_reg[6:0], 1'h0};
    end

    // Pixel and background flag from flip-flops
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pixel_out      <= 2'h0;
            background_out <= 1'b1;
        end else begin
            pixel_out      <= info.two_bit ? gfx_reg[7:6]
                                           : {1'b0, gfx_reg[7]};
            background_out <= !pf_enabled || !pf_active_reg;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_buf_first_line: assert property (@(posedge clk_in) disable iff (rst_in)
        buf_we |-> first_line_in && (name_slot || bitmap_slot))
        else $error("buffer written outside a first-line fetch slot");
    a_no_dma_off: assert property (@(posedge clk_in) disable iff (rst_in)
        !pf_enabled |-> !dma_req_out)
        else $error("bus request while playfield disabled");
    a_bg_when_off: assert property (@(posedge clk_in) disable iff (rst_in)
        !pf_enabled |=> background_out)
        else $error("playfield shown while disabled");
    a_ring_blank_clr: assert property (@(posedge clk_in)
        disable iff (rst_in)
        blank_mode |=> dma_ring_reg == 8'h0)
        else $error("dma ring not cleared in blank");
    a_idx_at_start: assert property (@(posedge clk_in) disable iff (rst_in)
        start_evt |=> buf_idx_reg == 6'h0 && pf_active_reg)
        else $error("buffer index not reset at start");
    a_start_enabled: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(pf_active_reg) |-> $past(pf_enabled))
        else $error("playfield started while disabled");
    a_sclk_special: assert property (@(posedge clk_in) disable iff (rst_in)
        special ##1 special |-> sclk_reg == 4'h0 && gfx_reg == 8'h0)
        else $error("shift state not cleared in cycles 0-7");
    a_inject_stop: assert property (@(posedge clk_in) disable iff (rst_in)
        stop_evt && !blank_mode |=> !dma_ring_reg[0])
        else $error("ring bit not cleared at stop");
    a_scan_off_pre: assert property (@(posedge clk_in) disable iff (rst_in)
        (!pf_active_reg && dma_ring_reg == 8'h0) |-> !mem_scan_inc_out)
        else $error("scan counter moved before playfield start");
endmodule : pfdma_line_buffer
`default_nettype wire

/* verification/pfdma_mem_model.sv */
/*
 * Memory bus model for the playfield fetch block.
 * Assumes fetch requests are one-clock pulses answered in the same cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module pfdma_mem_model
    import pfdma_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       dma_req_in,
    input  wire logic [1:0] dma_kind_in,
    output logic      [7:0] bus_data_out
);
    // ------------------------------------------------------------
    // Data pattern
    // ------------------------------------------------------------
    logic [5:0] seq_reg;
    logic [7:0] last_reg;
    logic [7:0] word;

    // Each answer carries the fetch kind and a running sequence number
    assign word = {dma_kind_in, seq_reg};

    // Sequence and last value advance on every answered slot
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            seq_reg  <= 6'h00;
            last_reg <= 8'h00;
        end else if (dma_req_in) begin
            seq_reg  <= seq_reg + 6'h01;
            last_reg <= word;
        end
    end

    // Released bus shows the inverse, so stale captures stand out
    assign bus_data_out = dma_req_in ? word : ~last_reg;
endmodule : pfdma_mem_model
`default_nettype wire

/* verification/pfdma_line_buffer_tb.sv */
/*
 * Self-checking bench for the playfield fetch block.
 * Assumes a zero-wait APB slave and a free-running 114-cycle line counter.
 */
`timescale 1ns/1ps
`default_nettype none
module pfdma_line_buffer_tb
    import pfdma_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        clk_in, rst_in, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  mode;
    logic        first_line, vblank, dma_req, scan_inc, bg, inv, err;
    logic [7:0]  bus_data;
    logic [1:0]  dma_kind, pixel;
    logic [6:0]  cycle, first_cyc, c0;
    int          n_fail, check_count, n_name, n_bm, n_chr, n_inc, n_bgl;
    int          n_pix;
    logic [3:0]  modes [3] = '{4'he, 4'ha, 4'h8};
    int          mult [3]  = '{4, 2, 1};

    pfdma_line_buffer u_pfdma_line_buffer (
        .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .mode_in(mode), .first_line_in(first_line),
        .vblank_in(vblank), .bus_data_in(bus_data), .dma_req_out(dma_req),
        .dma_kind_out(dma_kind), .mem_scan_inc_out(scan_inc),
        .pixel_out(pixel), .background_out(bg), .invert_out(inv),
        .cycle_out(cycle));

    pfdma_mem_model u_pfdma_mem_model (
        .clk_in(clk_in), .rst_in(rst_in), .dma_req_in(dma_req),
        .dma_kind_in(dma_kind), .bus_data_out(bus_data));

    // Colour clock, 50 ns period
    always #25 clk_in = ~clk_in;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic end_of_test;
        if (n_fail == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %0h want %0h",
                     $time, what, got, exp);
        end
    endtask : chk

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk_in);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        chk(n < 16, 1, "apb answer");
    endtask : apb

    task automatic at_cycle(input logic [6:0] c);
        int n;
        n = 0;
        do begin
            @(negedge clk_in);
            n++;
        end while (cycle !== c && n < 600);
        chk(n < 600, 1, "cycle wait");
    endtask : at_cycle

    task automatic sync_line;
        at_cycle(7'h71);
        at_cycle(7'h00);
    endtask : sync_line

    task automatic cfg(input logic [1:0] w, input logic [3:0] hs,
                       input logic [3:0] m, input logic fl, input logic vb);
        apb(1'b1, PFDMA_DMA_CONTROL_OFF, {30'h0, w});
        apb(1'b1, PFDMA_HSCROLL_OFF, {28'h0, hs});
        @(posedge clk_in);
        mode       <= m;
        first_line <= fl;
        vblank     <= vb;
    endtask : cfg

    // Counts fetch slots, scan steps and non-background clocks over one whole scan line
    task automatic measure;
        n_name = 0;
        n_bm = 0;
        n_chr = 0;
        n_inc = 0;
        n_bgl = 0;
        n_pix = 0;
        first_cyc = 7'h7f;
        sync_line();
        repeat (228) begin
            if (dma_req === 1'b1) begin
                if (first_cyc == 7'h7f) first_cyc = cycle;
                if (dma_kind === 2'h1) n_name++;
                if (dma_kind === 2'h2) n_bm++;
                if (dma_kind === 2'h3) n_chr++;
            end
            if (scan_inc === 1'b1) n_inc++;
            if (bg === 1'b0) n_bgl++;
            if (pixel !== 2'h0) n_pix++;
            @(negedge clk_in);
        end
    endtask : measure

    // Width rewritten at a given cycle of a first scan line in mode 8
    task automatic mid(input logic [1:0] w0, input logic [6:0] c,
                       input logic [1:0] w1);
        cfg(w0, 4'h0, 4'h8, 1'b1, 1'b0);
        fork
            measure();
            begin
                sync_line();
                at_cycle(c);
                apb(1'b1, PFDMA_DMA_CONTROL_OFF, {30'h0, w1});
            end
        join
    endtask : mid

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        apb(1'b0, PFDMA_DMA_CONTROL_OFF, 32'h0);
        chk(rd, {30'h0, PFDMA_DMA_CONTROL_RST}, "width reset");
        apb(1'b1, PFDMA_HSCROLL_OFF, 32'hff);
        apb(1'b0, PFDMA_HSCROLL_OFF, 32'h0);
        chk(rd, 32'hf, "scroll readback");
        apb(1'b1, 12'h00c, 32'h3);
        chk(err, 1'b1, "unmapped error");
        apb(1'b0, 12'h00c, 32'h0);
        chk(rd, 32'h0, "unmapped read");
    endtask : t_regs

    task automatic t_counts;
        for (int w = 1; w < 4; w++) begin
            for (int m = 0; m < 3; m++) begin
                cfg(w[1:0], 4'h0, modes[m], 1'b1, 1'b0);
                measure();
                chk(n_bm, (6 + 2 * w) * mult[m], "bitmap loads");
                chk(n_inc, (6 + 2 * w) * mult[m], "scan steps");
                chk(n_name + n_chr, 0, "no char fetch");
                chk(n_pix > 0, 1, "pixels shifted out");
            end
        end
        // Repeat line in text mode replays bitmap bytes as names
        cfg(2'h2, 4'h0, 4'h2, 1'b0, 1'b0);
        measure();
        chk(inv, 1'b1, "replayed names");
        chk(n_name, 0, "no name fetch on repeat");
        cfg(2'h2, 4'h0, 4'h2, 1'b1, 1'b0);
        measure();
        chk(n_name, 40, "name loads");
        chk(n_chr, 40, "char data fetches");
        chk(n_bm, 0, "no bitmap in text");
        chk(inv, 1'b0, "fresh names");
    endtask : t_counts

    task automatic t_start;
        cfg(2'h1, 4'h0, 4'h8, 1'b1, 1'b0);
        measure();
        c0 = first_cyc;
        chk(c0 >= 24 && c0 < 32, 1, "narrow start");
        cfg(2'h1, 4'h4, 4'h8, 1'b1, 1'b0);
        measure();
        chk(first_cyc, c0 + 7'h02, "scroll delay");
        cfg(2'h1, 4'h5, 4'h8, 1'b1, 1'b0);
        measure();
        chk(first_cyc, c0 + 7'h02, "scroll bit 0 unused");
    endtask : t_start

    task automatic t_moves;
        mid(2'h1, 7'h0c, 2'h3);
        chk(n_bm + n_inc, 0, "late earlier start");
        mid(2'h1, 7'h32, 2'h3);
        chk(n_bm, 10, "stop extended");
        mid(2'h3, 7'h5f, 2'h1);
        chk(n_bm, 12, "fallback wide stop");
        mid(2'h1, 7'h28, 2'h0);
        chk(n_inc, 10, "counter keeps going");
        chk(n_bm > 0 && n_bm < 8, 1, "requests suppressed");
        chk(n_bgl > 0 && n_bgl < 160, 1, "background when off");
    endtask : t_moves

    task automatic t_off;
        cfg(2'h0, 4'h0, 4'he, 1'b1, 1'b0);
        measure();
        chk(n_bm + n_name + n_chr + n_inc, 0, "width off");
        chk(n_bgl, 0, "background only");
        chk(n_pix, 0, "no pixels when off");
        cfg(2'h2, 4'h0, 4'h0, 1'b1, 1'b0);
        measure();
        chk(n_bm + n_name + n_chr, 0, "blank line");
        cfg(2'h2, 4'h0, 4'he, 1'b1, 1'b1);
        measure();
        chk(n_bm + n_name + n_chr, 0, "vertical blank");
        cfg(2'h2, 4'h0, 4'he, 1'b0, 1'b0);
        measure();
        chk(n_inc, 0, "repeat line no load");
    endtask : t_off

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        rst_in = 1'b1;
        {psel, penable, pwrite} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        mode = 4'h0;
        first_line = 1'b0;
        vblank = 1'b0;
        n_fail = 0;
        check_count = 0;
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        t_regs();
        t_counts();
        t_start();
        t_moves();
        t_off();
        end_of_test();
    end

    // About 45 lines of traffic are expected; allow ample margin
    initial begin
        #3_000_000;
        n_fail++;
        $display("unexpected at %0t: watchdog expired", $time);
        end_of_test();
    end
endmodule : pfdma_line_buffer_tb
`default_nettype wire
